//--- logic/sleep_gate_defines.svh
/*
 * offsets, field positions, reset values and widths of the sleep-mode
 * port clock gating block.
 * assumes: included by the package and the design file.
 */
`ifndef SLEEP_GATE_DEFINES_SVH
`define SLEEP_GATE_DEFINES_SVH

`define SCTL_BASE_ADDR 32'h400F_E000
`define RUN_GATE_OFFSET 12'h108
`define SLEEP_GATE_OFFSET 12'h118
`define DEEP_GATE_OFFSET 12'h128
`define RUN_CFG_OFFSET 12'h060
`define MODE_CTRL_OFFSET 12'h200
`define PORT_COUNT 8
`define GATE_FIELD_MSB 7
`define GATE_RESET 8'h00
`define AUTO_GATE_BIT 27
`define MODE_FIELD_MSB 1
`define MODE_RESERVED 2'b11
`define RSVD_ZERO 24'h00_0000

`endif

//--- logic/sleep_gate_pkg.sv
/*
 * types of the sleep-mode port clock gating block.
 * assumes: the defines header is on the include path.
 */
`include "sleep_gate_defines.svh"

package sleep_gate_pkg;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_DEEP = 2'b10
    } power_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic sel;
        logic [7:0] portSel;
    } port_access_t;

endpackage : sleep_gate_pkg

//--- logic/sleep_port_clock_gating.sv
/*
 * sleep-mode port clock gating control for ports a to h.
 * holds the run, sleep and deep-sleep port gating registers, the auto
 * gating select and a power mode register, all reached over an apb
 * slave, and drives one clock enable per port from the register that
 * the current mode and the auto gating select pick; also flags a port access that targets a
 * port whose clock is off.
 * register map, byte offsets from the control base:
 *   0x060 run clock config, auto gating select at bit 27
 *   0x108 run port clock gate
 *   0x118 sleep port clock gate
 *   0x128 deep sleep port clock gate
 *   0x200 power mode, bits 1:0
 * the port fields of all three gate registers share one layout.
 * writes to read-only bits are dropped.
 * a write of a refused mode code leaves the mode unchanged.
 * assumes: one clock core_clk and a synchronous, active high sys_rst;
 * the port bus fabric runs on core_clk and gives a one-hot port select
 * with each access, so that select passes no synchroniser;
 * the apb master keeps to setup then access, one word per transfer;
 * any other address in the map answers with an error.
 */
// What this block does
// - while the sleep register is in effect a port with its bit set gets a clock, else none.
// - an access to a port whose clock is gated off is answered with a bus fault.
// - after reset the sleep gating register reads zero; the mode is run and the run register is zero, so every port is unclocked.
// - port a sits at bit 0 through port h at bit 7, each read and write.
// - bits 31 to 8 are read only and read as zero.
// - the sleep register governs only in sleep; run and deep sleep have their own.
// - the per-mode sleep registers apply only when auto gating select is set.
// - the sleep gating register decodes at offset 0x118 of the control base.
`timescale 1ns/1ps
`include "sleep_gate_defines.svh"

module sleep_port_clock_gating (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire sleep_gate_pkg::apb_req_t apbReq,
    output sleep_gate_pkg::apb_rsp_t apbRsp,
    input wire sleep_gate_pkg::port_access_t portAccess,
    output logic portFault,
    output logic [7:0] portClockEnable,
    output sleep_gate_pkg::power_mode_t powerMode
);
    import sleep_gate_pkg::*;

    // register state
    logic [7:0] runGate_ff;
    logic [7:0] sleepGate_ff;
    logic [7:0] deepGate_ff;
    logic autoGate_ff;
    power_mode_t mode_ff;
    logic [7:0] portEnable_ff;
    logic fault_ff;
    logic [31:0] rdata_ff;

    // next values
    logic [7:0] nxt_runGate;
    logic [7:0] nxt_sleepGate;
    logic [7:0] nxt_deepGate;
    logic nxt_autoGate;
    power_mode_t nxt_mode;
    logic [7:0] nxt_portEnable;
    logic nxt_fault;
    logic [31:0] nxt_rdata;
    logic [7:0] portFaultHit;

    // full-address match of one register of this block
    function automatic logic hit(
        input logic [31:0] addr,
        input logic [11:0] off
    );
        hit = (addr == (`SCTL_BASE_ADDR | {20'h0_0000, off}));
    endfunction : hit

    // mode code 3 names no mode and is refused
    function automatic logic legalMode(
        input logic [1:0] code
    );
        legalMode = (code != `MODE_RESERVED);
    endfunction : legalMode

    // reserved bits above the port field read as zero
    function automatic logic [31:0] gateWord(
        input logic [7:0] gate
    );
        gateWord = {`RSVD_ZERO, gate};
    endfunction : gateWord

    // gate applied in a mode, sleep registers only with auto select
    function automatic logic [7:0] modeGate(
        input power_mode_t mode,
        input logic autoSel,
        input logic [7:0] runGate,
        input logic [7:0] sleepGate,
        input logic [7:0] deepGate
    );
        modeGate = runGate;
        unique case (mode)
            MODE_RUN: begin
                modeGate = runGate;
            end
            MODE_SLEEP: begin
                if (autoSel) begin
                    modeGate = sleepGate;
                end else begin
                    modeGate = runGate;
                end
            end
            MODE_DEEP: begin
                if (autoSel) begin
                    modeGate = deepGate;
                end else begin
                    modeGate = runGate;
                end
            end
            default: begin
                modeGate = runGate;
            end
        endcase
    endfunction : modeGate

    // bus phases
    wire logic access = apbReq.psel & apbReq.penable;
    wire logic setup = apbReq.psel & ~apbReq.penable;
    wire logic wrEn = access & apbReq.pwrite;

    // register decode
    wire logic hitRun = hit(apbReq.paddr, `RUN_GATE_OFFSET);
    wire logic hitSleep = hit(apbReq.paddr, `SLEEP_GATE_OFFSET);
    wire logic hitDeep = hit(apbReq.paddr, `DEEP_GATE_OFFSET);
    wire logic hitCfg = hit(apbReq.paddr, `RUN_CFG_OFFSET);
    wire logic hitMode = hit(apbReq.paddr, `MODE_CTRL_OFFSET);
    wire logic hitAny = hitRun | hitSleep | hitDeep | hitCfg | hitMode;
    wire logic [4:0] hitVec = {hitMode, hitCfg, hitDeep, hitSleep, hitRun};

    // write data fields
    wire logic [7:0] wrGate = apbReq.pwdata[`GATE_FIELD_MSB:0];
    wire power_mode_t modeField = power_mode_t'(apbReq.pwdata[1:0]);
    wire logic modeLegal = legalMode(apbReq.pwdata[`MODE_FIELD_MSB:0]);

    // write strobes, a refused mode code writes nothing
    wire logic wrRun = wrEn & hitRun;
    wire logic wrSleep = wrEn & hitSleep;
    wire logic wrDeep = wrEn & hitDeep;
    wire logic wrCfg = wrEn & hitCfg;
    wire logic wrModeEn = wrEn & hitMode & modeLegal;

    // next register values
    always_comb begin
        nxt_runGate = runGate_ff;
        nxt_sleepGate = sleepGate_ff;
        nxt_deepGate = deepGate_ff;
        nxt_autoGate = autoGate_ff;
        nxt_mode = mode_ff;
        if (wrRun) begin
            nxt_runGate = wrGate;
        end
        if (wrSleep) begin
            nxt_sleepGate = wrGate;
        end
        if (wrDeep) begin
            nxt_deepGate = wrGate;
        end
        if (wrCfg) begin
            nxt_autoGate = apbReq.pwdata[`AUTO_GATE_BIT];
        end
        if (wrModeEn) begin
            nxt_mode = modeField;
        end
    end

    // enable of each port for the current mode
    assign nxt_portEnable = modeGate(mode_ff, autoGate_ff, runGate_ff,
        sleepGate_ff, deepGate_ff);

    // read data, captured in setup and cleared outside it
    wire logic [31:0] cfgWord = {4'h0, autoGate_ff, 27'h000_0000};
    wire logic [31:0] modeWord = {30'h0000_0000, mode_ff};
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (setup) begin
            unique case (hitVec)
                5'b0_0001: begin
                    nxt_rdata = gateWord(runGate_ff);
                end
                5'b0_0010: begin
                    nxt_rdata = gateWord(sleepGate_ff);
                end
                5'b0_0100: begin
                    nxt_rdata = gateWord(deepGate_ff);
                end
                5'b0_1000: begin
                    nxt_rdata = cfgWord;
                end
                5'b1_0000: begin
                    nxt_rdata = modeWord;
                end
                default: begin
                    nxt_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // per-port fault term: selected and not clocked now
    genvar p;
    generate
        for (p = 0; p < `PORT_COUNT; p++) begin : g_port
            assign portFaultHit[p] = portAccess.portSel[p]
                & ~portEnable_ff[p];
        end
    endgenerate

    // fault answers the access one cycle later
    assign nxt_fault = portAccess.sel & (|portFaultHit);

    // run gate register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            runGate_ff <= `GATE_RESET;
        end else begin
            runGate_ff <= nxt_runGate;
        end
    end

    // sleep gate register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sleepGate_ff <= `GATE_RESET;
        end else begin
            sleepGate_ff <= nxt_sleepGate;
        end
    end

    // deep sleep gate register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            deepGate_ff <= `GATE_RESET;
        end else begin
            deepGate_ff <= nxt_deepGate;
        end
    end

    // auto gating select
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            autoGate_ff <= 1'b0;
        end else begin
            autoGate_ff <= nxt_autoGate;
        end
    end

    // power mode
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode_ff <= MODE_RUN;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // applied port enables
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            portEnable_ff <= `GATE_RESET;
        end else begin
            portEnable_ff <= nxt_portEnable;
        end
    end

    // port fault
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= nxt_fault;
        end
    end

    // read data
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // apb: no wait states, unmapped addresses answer with an error
    assign apbRsp.pready = 1'b1;
    assign apbRsp.pslverr = access & ~hitAny;
    assign apbRsp.prdata = rdata_ff;

    // port side outputs
    assign portFault = fault_ff;
    assign portClockEnable = portEnable_ff;
    assign powerMode = mode_ff;

endmodule : sleep_port_clock_gating

//--- tb/sleep_gate_properties.sv
/* port assertions for the sleep gating block.
   assumes: bound to its top module, one clock. */
`timescale 1ns/1ps
module sleep_gate_properties
    import sleep_gate_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire apb_req_t apbReq,
    input wire apb_rsp_t apbRsp,
    input wire port_access_t portAccess,
    input wire logic portFault,
    input wire logic [7:0] portClockEnable,
    input wire power_mode_t powerMode
);
    wire apbAccess = apbReq.psel && apbReq.penable;
    wire sleepHit = apbAccess && apbReq.paddr == 32'h400F_E118;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    chk_fault_gated: assert property (
        portAccess.sel |=> portFault ==
        |$past(portAccess.portSel & ~portClockEnable)) else $error("fault");
    chk_fault_idle: assert property (
        !portAccess.sel |=> !portFault) else $error("idle");
    chk_reset_clear: assert property (
        disable iff (1'b0) sys_rst |=> portClockEnable == 8'h00)
        else $error("reset");
    chk_mode_reset: assert property (
        disable iff (1'b0) sys_rst |=> powerMode == MODE_RUN)
        else $error("mode");
    chk_upper_zero: assert property (
        sleepHit && !apbReq.pwrite |-> apbRsp.prdata[31:8] == 24'h00_0000)
        else $error("upper");
    chk_sleep_decode: assert property (
        apbAccess && apbReq.paddr[31:4] == 28'h400_FE11
        |-> apbRsp.pslverr == (apbReq.paddr[3:0] != 4'h8)) else $error("dec");
    chk_run_ignores: assert property (
        sleepHit && powerMode == MODE_RUN ##1 powerMode == MODE_RUN
        |=> $stable(portClockEnable)) else $error("run");
    chk_enable_hold: assert property (
        !(apbAccess && apbReq.pwrite) |=> ##1 $stable(portClockEnable))
        else $error("hold");
endmodule : sleep_gate_properties
bind sleep_port_clock_gating sleep_gate_properties props_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .portAccess(portAccess), .portFault(portFault),
    .portClockEnable(portClockEnable), .powerMode(powerMode));

//--- tb/tb_top.sv
/* bench for the sleep gating block.
   assumes: checker bound from its own file. */
`timescale 1ns/1ps
module tb_top;
    import sleep_gate_pkg::*;
    logic core_clk, sys_rst, portFault, selSeen;
    apb_req_t apbReq;
    apb_rsp_t apbRsp;
    port_access_t portAccess;
    logic [7:0] portClockEnable;
    power_mode_t powerMode;
    logic [31:0] expQ[$], v, rg;
    logic [10:0] faultQ[$], fe;
    logic errQ[$];
    int err_count, checks_done;
    sleep_port_clock_gating sleep_port_clock_gating_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .apbReq(apbReq),
        .apbRsp(apbRsp), .portAccess(portAccess), .portFault(portFault),
        .portClockEnable(portClockEnable), .powerMode(powerMode));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic cmp(input string n, input logic [31:0] e, s);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : cmp
    task automatic tally_and_finish;
        if (err_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic w, logic [11:0] o, logic [31:0] d);
        int i = 0;
        if (!w) expQ.push_back(d);
        errQ.push_back(!(o inside {12'h060, 12'h108, 12'h118, 12'h128,
            12'h200}));
        apbReq <= '{1'b1, 1'b0, w, 32'h400F_E000 + o, d};
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        do @(posedge core_clk); while (!apbRsp.pready && ++i < 9);
        if (i == 9) begin
            err_count++;
            tally_and_finish;
        end
        apbReq <= '0;
        @(posedge core_clk);
    endtask : apb
    task automatic acc(input logic [7:0] g, power_mode_t m);
        for (int p = 0; p < 8; p++) begin
            faultQ.push_back({m, !g[p], g});
            portAccess <= '{1'b1, 8'h01 << p};
            @(posedge core_clk);
        end
        portAccess <= '0;
    endtask : acc
    always @(posedge core_clk) selSeen <= portAccess.sel;
    always @(negedge core_clk) begin
        if (selSeen) begin
            fe = faultQ.pop_front();
            cmp("portFault", fe[8], portFault);
            cmp("portClockEnable", fe[7:0], portClockEnable);
            cmp("powerMode", fe[10:9], powerMode);
        end
        if (apbReq.psel && apbReq.penable)
            cmp("pslverr", errQ.pop_front(), apbRsp.pslverr);
        if (apbReq.psel && apbReq.penable && !apbReq.pwrite)
            cmp("prdata", expQ.pop_front(), apbRsp.prdata);
    end
    initial begin
        sys_rst = 1'b1;
        selSeen = 1'b0;
        apbReq = '0;
        portAccess = '0;
        v = $urandom(32'hc795);
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        apb(0, 12'h118, 32'h0);
        rg = $urandom;
        apb(1, 12'h108, rg);
        apb(1, 12'h118, 32'hFFFF_FFFF);
        acc(rg[7:0], MODE_RUN);
        apb(1, 12'h060, 32'h0800_0000);
        apb(1, 12'h200, 32'h0000_0001);
        repeat (3) begin
            v = $urandom;
            apb(1, 12'h118, v);
            apb(0, 12'h118, v & 32'h0000_00FF);
            acc(v[7:0], MODE_SLEEP);
        end
        apb(1, 12'h060, 32'h0);
        acc(rg[7:0], MODE_SLEEP);
        apb(1, 12'h200, 32'h0000_0002);
        apb(1, 12'h128, ~rg);
        apb(1, 12'h200, 32'h0000_0003);
        acc(rg[7:0], MODE_DEEP);
        apb(1, 12'h060, 32'h0800_0000);
        acc(~rg[7:0], MODE_DEEP);
        apb(0, 12'h11C, 32'h0);
        tally_and_finish;
    end
endmodule : tb_top
